// File: shared/fuaeb_pkg.sv
// package: register map, field layout and block map of the upper-area flash controller
package fuaeb_pkg;
   // register word offsets (byte addresses on the avalon bus)
   localparam logic [3:0] ADDR_UPPER_MODE   = 4'h0;
   localparam logic [3:0] ADDR_ERASE_LOW    = 4'h4;
   localparam logic [3:0] ADDR_ERASE_HIGH   = 4'h8;
   localparam logic [3:0] ADDR_PERMIT       = 4'hc;

   // upper-area mode control fields
   localparam int BIT_FAULT        = 7;
   localparam int BIT_RSVD         = 6;
   localparam int BIT_ERASE_SETUP  = 5;
   localparam int BIT_PROG_SETUP   = 4;
   localparam int BIT_ERASE_CHECK  = 3;
   localparam int BIT_PROG_CHECK   = 2;
   localparam int BIT_ERASE_GO     = 1;
   localparam int BIT_PROG_GO      = 0;

   // permit register fields
   localparam int BIT_SOFT_PERMIT  = 0;
   localparam int BIT_PIN_PERMIT   = 1;

   localparam logic [7:0] REG_RESET      = 8'h00;
   localparam logic [7:0] LOW_SEL_MASK   = 8'h0f;
   localparam int         NUM_BLOCKS     = 12;
   localparam int         LOW_BLOCKS     = 4;

   // upper area and block map
   localparam logic [23:0] UPPER_BASE    = 24'h020000;
   localparam logic [23:0] UPPER_LAST    = 24'h03ffff;
   localparam logic [23:0] BIG_BLOCK_SZ  = 24'h008000;
   localparam logic [23:0] BLK7_BASE     = 24'h038000;
   localparam logic [23:0] BLK7_SIZE     = 24'h007000;
   localparam logic [23:0] SMALL_BASE    = 24'h03f000;
   localparam logic [23:0] SMALL_SIZE    = 24'h000400;
   localparam int          NUM_BIG       = 7;
   localparam int          BLK_SEVEN     = 7;
endpackage

// File: design/fuaeb_block_map.sv
// block map: finds the erase block that holds an address
module fuaeb_block_map
   import fuaeb_pkg::*;
(
   // lookup
   input  wire logic [23:0] addr_i,
   output logic [11:0]      block_hit_o
);
   // ------------------------------------------------------------
   // address decode
   // ------------------------------------------------------------
   // block extents
   always_comb
   begin
      block_hit_o = 12'h000;
      for (int i = 0; i < NUM_BLOCKS; i++)
      begin
         logic [23:0] base;
         logic [23:0] size;
         base = 24'h000000;
         size = 24'h000000;
         if (i < NUM_BIG)
         begin
            base = 24'(i) * BIG_BLOCK_SZ;
            size = BIG_BLOCK_SZ;
         end
         else if (i == BLK_SEVEN)
         begin
            base = BLK7_BASE;
            size = BLK7_SIZE;
         end
         else
         begin
            base = SMALL_BASE + 24'(i - BLK_SEVEN - 1) * SMALL_SIZE;
            size = SMALL_SIZE;
         end
         block_hit_o[i] = (addr_i >= base) && (addr_i < base + size);
      end
   end
endmodule

// File: design/fuaeb_ctrl.sv
// upper-area program/erase control with erase-block selection, avalon-mm slave
//
// Local design decisions: the Avalon-MM register port and the register offsets.
module fuaeb_ctrl
   import fuaeb_pkg::*;
(
   // clock and reset
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   // avalon-mm slave
   input  wire logic [3:0]  avs_address_i,
   input  wire logic        avs_read_i,
   input  wire logic        avs_write_i,
   input  wire logic [31:0] avs_writedata_i,
   input  wire logic [3:0]  avs_byteenable_i,
   output logic [31:0]      avs_readdata_o,
   output logic             avs_waitrequest_o,
   output logic [1:0]       avs_response_o,
   // system state
   input  wire logic        hw_standby_i,
   input  wire logic        sw_standby_i,
   input  wire logic        flash_enable_i,
   input  wire logic        pin_write_permit_i,
   input  wire logic        error_detect_i,
   // array side
   input  wire logic [23:0] target_addr_i,
   output logic             erase_setup_upper_o,
   output logic             program_setup_upper_o,
   output logic             erase_check_upper_o,
   output logic             program_check_upper_o,
   output logic             erase_go_upper_o,
   output logic             program_go_upper_o,
   output logic             target_erasable_o,
   output logic             flash_fault_flag_o
);
   // ------------------------------------------------------------
   // pin synchroniser
   // ------------------------------------------------------------
   logic [2:0] pin_sync_r;
   logic       pin_permit_r;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pin_sync_r <= 3'h0;
      else
         pin_sync_r <= {pin_sync_r[1:0], pin_write_permit_i};
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         pin_permit_r <= 1'b0;
      else if (pin_sync_r[1] == pin_sync_r[2])
         pin_permit_r <= pin_sync_r[2];
   end

   // ------------------------------------------------------------
   // bus handshake
   // ------------------------------------------------------------
   // one wait state: accept on the second cycle of a request
   logic ack_r;
   logic req;
   logic wr_acc;
   logic rd_acc;
   logic lane0;
   logic [7:0] wbyte;

   assign req    = avs_read_i | avs_write_i;
   assign wr_acc = avs_write_i & ack_r;
   assign rd_acc = avs_read_i & ack_r;
   assign lane0  = avs_byteenable_i[0];
   assign wbyte  = avs_writedata_i[7:0];

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         ack_r <= 1'b0;
      else
         ack_r <= req & ~ack_r;
   end

   function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
      return a == off;
   endfunction

   // ------------------------------------------------------------
   // clear conditions
   // ------------------------------------------------------------
   logic soft_permit_r;
   logic both_permit;
   logic standby;
   logic ctrl_clear;

   assign both_permit = pin_permit_r & soft_permit_r;
   assign standby     = hw_standby_i | sw_standby_i;
   assign ctrl_clear  = standby | ~both_permit;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         soft_permit_r <= 1'b0;
      else if (standby || !pin_permit_r)
         soft_permit_r <= 1'b0;
      else if (wr_acc && lane0 && flash_enable_i && hit(avs_address_i, ADDR_PERMIT))
         soft_permit_r <= wbyte[BIT_SOFT_PERMIT];
   end

   // ------------------------------------------------------------
   // upper mode control
   // ------------------------------------------------------------
   logic       fault_r;
   logic [5:0] mode_r;
   logic [5:0] mode_nxt;
   logic       mode_wr;

   assign mode_wr = wr_acc && lane0 && flash_enable_i && hit(avs_address_i, ADDR_UPPER_MODE);

   // only reset or hardware standby clears
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         fault_r <= 1'b0;
      else if (error_detect_i)
         fault_r <= 1'b1;
      else if (hw_standby_i)
         fault_r <= 1'b0;
   end

   always_comb
   begin
      mode_nxt = mode_r;
      if (mode_wr)
      begin
         mode_nxt[BIT_ERASE_SETUP] = wbyte[BIT_ERASE_SETUP];
         mode_nxt[BIT_PROG_SETUP]  = wbyte[BIT_PROG_SETUP];
         mode_nxt[BIT_ERASE_CHECK] = wbyte[BIT_ERASE_CHECK];
         mode_nxt[BIT_PROG_CHECK]  = wbyte[BIT_PROG_CHECK];
         mode_nxt[BIT_ERASE_GO] = wbyte[BIT_ERASE_GO] & mode_r[BIT_ERASE_SETUP];
         mode_nxt[BIT_PROG_GO]  = wbyte[BIT_PROG_GO] & mode_r[BIT_PROG_SETUP];
      end
   end

   // clear on standby or lost permit
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         mode_r <= REG_RESET[5:0];
      else if (ctrl_clear)
         mode_r <= REG_RESET[5:0];
      else
         mode_r <= mode_nxt;
   end

   // ------------------------------------------------------------
   // erase block selects
   // ------------------------------------------------------------
   logic [7:0] sel_low_r;
   logic [7:0] sel_high_r;

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || ctrl_clear)
         sel_low_r <= REG_RESET;
      else if (wr_acc && lane0 && flash_enable_i && hit(avs_address_i, ADDR_ERASE_LOW))
         sel_low_r <= wbyte & LOW_SEL_MASK;
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i || ctrl_clear)
         sel_high_r <= REG_RESET;
      else if (wr_acc && lane0 && flash_enable_i && hit(avs_address_i, ADDR_ERASE_HIGH))
         sel_high_r <= wbyte;
   end

   // ------------------------------------------------------------
   // array outputs
   // ------------------------------------------------------------
   logic [11:0] block_sel;
   logic [11:0] block_hit;
   logic        go_ok;

   assign block_sel = {sel_high_r, sel_low_r[LOW_BLOCKS-1:0]};
   assign go_ok = ~fault_r & both_permit & flash_enable_i;

   fuaeb_block_map u_map
   (
      .addr_i      (target_addr_i),
      .block_hit_o (block_hit)
   );

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
      begin
         erase_setup_upper_o   <= 1'b0;
         program_setup_upper_o <= 1'b0;
         erase_check_upper_o   <= 1'b0;
         program_check_upper_o <= 1'b0;
         erase_go_upper_o      <= 1'b0;
         program_go_upper_o    <= 1'b0;
         target_erasable_o     <= 1'b0;
         flash_fault_flag_o    <= 1'b0;
      end
      else
      begin
         erase_setup_upper_o   <= mode_r[BIT_ERASE_SETUP] & go_ok;
         program_setup_upper_o <= mode_r[BIT_PROG_SETUP] & go_ok;
         erase_check_upper_o   <= mode_r[BIT_ERASE_CHECK] & go_ok;
         program_check_upper_o <= mode_r[BIT_PROG_CHECK] & go_ok;
         erase_go_upper_o      <= mode_r[BIT_ERASE_GO] & go_ok;
         program_go_upper_o    <= mode_r[BIT_PROG_GO] & go_ok;
         target_erasable_o     <= |(block_sel & block_hit) & go_ok;
         flash_fault_flag_o    <= fault_r;
      end
   end

   // ------------------------------------------------------------
   // read path
   // ------------------------------------------------------------
   logic [7:0] rd_byte;

   always_comb
   begin
      rd_byte = REG_RESET;
      if (flash_enable_i)
      begin
         case (avs_address_i)
            ADDR_UPPER_MODE: rd_byte = {fault_r, 1'b0, mode_r};
            ADDR_ERASE_LOW:  rd_byte = sel_low_r;
            ADDR_ERASE_HIGH: rd_byte = sel_high_r;
            ADDR_PERMIT:     rd_byte = {6'h00, pin_permit_r, soft_permit_r};
            default:         rd_byte = REG_RESET;
         endcase
      end
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         avs_readdata_o <= 32'h0000_0000;
      else if (req && !ack_r)
         avs_readdata_o <= {24'h000000, rd_byte};
   end

   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         avs_waitrequest_o <= 1'b1;
      else
         avs_waitrequest_o <= ~(req & ~ack_r);
   end

   // unmapped address answers slave error
   always_ff @(posedge clk_i)
   begin
      if (!rst_n_i)
         avs_response_o <= 2'b00;
      else if (req && !ack_r)
         avs_response_o <= (avs_address_i == ADDR_UPPER_MODE || avs_address_i == ADDR_ERASE_LOW
                            || avs_address_i == ADDR_ERASE_HIGH || avs_address_i == ADDR_PERMIT)
                           ? 2'b00 : 2'b10;
   end

   logic unused_rd;
   assign unused_rd = rd_acc;
endmodule

// File: test/fuaeb_ctrl_chk.sv
// checker: bus timing and gating properties of the upper-area flash controller
module fuaeb_ctrl_chk
   import fuaeb_pkg::*;
(
   // clock, reset, bus
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [3:0]  avs_address_i,
   input wire logic        avs_read_i,
   input wire logic        avs_write_i,
   input wire logic [31:0] avs_readdata_o,
   input wire logic        avs_waitrequest_o,
   // system state and array side
   input wire logic        sw_standby_i,
   input wire logic        hw_standby_i,
   input wire logic        flash_enable_i,
   input wire logic        error_detect_i,
   input wire logic        erase_setup_upper_o,
   input wire logic        program_setup_upper_o,
   input wire logic        erase_check_upper_o,
   input wire logic        program_check_upper_o,
   input wire logic        erase_go_upper_o,
   input wire logic        program_go_upper_o,
   input wire logic        target_erasable_o,
   input wire logic        flash_fault_flag_o
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   wire logic [6:0] act = {erase_setup_upper_o, program_setup_upper_o, erase_check_upper_o,
      program_check_upper_o, erase_go_upper_o, program_go_upper_o, target_erasable_o};
   wire logic done = !avs_waitrequest_o;
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   property p_fault_blocks;
      flash_fault_flag_o [*2] |-> act == 7'h00;
   endproperty
   a_fault_blocks: assert property (p_fault_blocks) else $error("active under fault");
   property p_fault_set;
      error_detect_i |-> ##[1:3] flash_fault_flag_o;
   endproperty
   a_fault_set: assert property (p_fault_set) else $error("fault not raised");
   property p_fault_keep;
      flash_fault_flag_o && !hw_standby_i && !$past(hw_standby_i) |=> flash_fault_flag_o;
   endproperty
   a_fault_keep: assert property (p_fault_keep) else $error("fault lost");
   property p_wait_one;
      done |=> avs_waitrequest_o;
   endproperty
   a_wait_one: assert property (p_wait_one) else $error("wait low too long");
   property p_answer;
      (avs_read_i || avs_write_i) && avs_waitrequest_o |-> ##[1:2] done;
   endproperty
   a_answer: assert property (p_answer) else $error("no answer");
   property p_top_zero;
      done |-> avs_readdata_o[31:8] == 24'h000000;
   endproperty
   a_top_zero: assert property (p_top_zero) else $error("upper read bits set");
   property p_rsvd;
      done && avs_read_i && avs_address_i == ADDR_UPPER_MODE |-> !avs_readdata_o[BIT_RSVD];
   endproperty
   a_rsvd: assert property (p_rsvd) else $error("reserved bit set");
   property p_off_read;
      done && avs_read_i && !flash_enable_i && !$past(flash_enable_i) |-> avs_readdata_o == 0;
   endproperty
   a_off_read: assert property (p_off_read) else $error("read while off");
   property p_standby;
      sw_standby_i [*3] |-> act == 7'h00;
   endproperty
   a_standby: assert property (p_standby) else $error("active in standby");
   property p_off_gate;
      !flash_enable_i [*2] |-> act == 7'h00;
   endproperty
   a_off_gate: assert property (p_off_gate) else $error("active while off");
   c_write: cover property (avs_write_i && done);
   c_fault: cover property ($rose(flash_fault_flag_o));
   c_erasable: cover property (target_erasable_o);
endmodule

bind fuaeb_ctrl fuaeb_ctrl_chk fuaeb_ctrl_chk_inst (.clk_i(clk_i), .rst_n_i(rst_n_i),
   .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
   .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
   .sw_standby_i(sw_standby_i), .hw_standby_i(hw_standby_i), .flash_enable_i(flash_enable_i),
   .error_detect_i(error_detect_i), .erase_setup_upper_o(erase_setup_upper_o),
   .program_setup_upper_o(program_setup_upper_o), .erase_check_upper_o(erase_check_upper_o),
   .program_check_upper_o(program_check_upper_o), .erase_go_upper_o(erase_go_upper_o),
   .program_go_upper_o(program_go_upper_o), .target_erasable_o(target_erasable_o),
   .flash_fault_flag_o(flash_fault_flag_o));

// File: test/fuaeb_ctrl_bench.sv
// testbench: register access, gating and block map of the upper-area controller
module fuaeb_ctrl_bench;
   import fuaeb_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic [3:0]  avs_address_i = 4'h0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = 32'h0;
   logic        hw_standby_i = 1'b0;
   logic        sw_standby_i = 1'b0;
   logic        flash_enable_i = 1'b1;
   logic        pin_write_permit_i = 1'b0;
   logic        error_detect_i = 1'b0;
   logic [23:0] target_addr_i = 24'h0;
   logic [31:0] avs_readdata_o, q;
   logic        avs_waitrequest_o, esu, psu, ech, pch, ego, pgo, erasable, fault;
   logic [3:0]  be = 4'h1;
   logic [1:0]  avs_response_o, rsp;
   logic [11:0] sel;
   logic [23:0] lo, hi;
   logic [7:0]  v;
   int          n_mismatch = 0;
   int          total_checks = 0;
   fuaeb_ctrl fuaeb_ctrl_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
      .avs_read_i(avs_read_i), .avs_write_i(avs_write_i), .avs_writedata_i(avs_writedata_i),
      .avs_byteenable_i(be), .avs_readdata_o(avs_readdata_o),
      .avs_waitrequest_o(avs_waitrequest_o), .avs_response_o(avs_response_o),
      .hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i), .flash_enable_i(flash_enable_i),
      .pin_write_permit_i(pin_write_permit_i), .error_detect_i(error_detect_i),
      .target_addr_i(target_addr_i), .erase_setup_upper_o(esu), .program_setup_upper_o(psu),
      .erase_check_upper_o(ech), .program_check_upper_o(pch), .erase_go_upper_o(ego),
      .program_go_upper_o(pgo), .target_erasable_o(erasable), .flash_fault_flag_o(fault));
   initial
   forever #25 clk_i = ~clk_i;
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task automatic tally_and_finish();
      if (n_mismatch == 0 && total_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e)
      begin
         n_mismatch++;
         $display("MISMATCH %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(posedge clk_i);
   endtask
   // called just after a rising edge; holds the request until waitrequest is seen low
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      int n;
      n = 0;
      avs_address_i <= a;
      avs_writedata_i <= {24'h000000, d};
      avs_write_i <= w;
      avs_read_i <= !w;
      do
      begin
         @(posedge clk_i);
         n++;
      end
      while (avs_waitrequest_o !== 1'b0 && n < 20);
      if (n >= 20)
         n_mismatch++;
      q = avs_readdata_o;
      rsp = avs_response_o;
      avs_write_i <= 1'b0;
      avs_read_i <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
   endtask
   task automatic rc(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(q, {24'h000000, e});
   endtask
   // ----------------------------------------------------------------
   // sequence
   // ----------------------------------------------------------------
   initial
   begin
      tick(20);
      rst_n_i <= 1'b1;
      tick(1);
      wr(ADDR_PERMIT, 8'h01);
      rc(ADDR_PERMIT, 8'h00);
      wr(ADDR_UPPER_MODE, 8'h20);
      rc(ADDR_UPPER_MODE, 8'h00);
      pin_write_permit_i <= 1'b1;
      tick(6);
      wr(ADDR_PERMIT, 8'h01);
      rc(ADDR_PERMIT, 8'h03);
      wr(ADDR_UPPER_MODE, 8'h02);
      rc(ADDR_UPPER_MODE, 8'h00);
      wr(ADDR_UPPER_MODE, 8'h01);
      rc(ADDR_UPPER_MODE, 8'h00);
      for (int i = 2; i < 6; i++)
      begin
         v = 8'h01 << i;
         wr(ADDR_UPPER_MODE, v);
         rc(ADDR_UPPER_MODE, v);
         chk({26'h0, esu, psu, ech, pch, ego, pgo}, {26'h0, v[5:0]});
      end
      wr(ADDR_UPPER_MODE, 8'h22);
      rc(ADDR_UPPER_MODE, 8'h22);
      chk({31'h0, ego}, 32'h1);
      wr(ADDR_UPPER_MODE, 8'h10);
      wr(ADDR_UPPER_MODE, 8'h11);
      // output flop follows the mode bit one edge later
      tick(1);
      chk({31'h0, pgo}, 32'h1);
      wr(ADDR_UPPER_MODE, 8'hc0);
      rc(ADDR_UPPER_MODE, 8'h00);
      wr(ADDR_ERASE_LOW, 8'h80);
      rc(ADDR_ERASE_LOW, 8'h00);
      for (int b = 0; b < 12; b++)
      begin
         sel = 12'h001 << b;
         hi = (b < 7) ? 24'h007fff : (b == 7) ? 24'h006fff : 24'h0003ff;
         lo = (b < 7) ? 24'(b * 32'h8000) :
              (b == 7) ? 24'h038000 : 24'(32'h3f000 + (b - 8) * 32'h400);
         hi = lo + hi;
         wr(ADDR_ERASE_LOW, {4'h0, sel[3:0]});
         wr(ADDR_ERASE_HIGH, sel[11:4]);
         rc(ADDR_ERASE_HIGH, sel[11:4]);
         for (int k = 0; k < 4; k++)
         begin
            target_addr_i <= (k == 0) ? lo - 24'h1 : (k == 1) ? lo : (k == 2) ? hi : hi + 24'h1;
            tick(3);
            chk({31'h0, erasable}, {31'h0, k == 1 || k == 2});
         end
      end
      // keep a selected target so the gating checks see a live output
      target_addr_i <= 24'h03fc00;
      tick(3);
      chk({31'h0, erasable}, 32'h1);
      flash_enable_i <= 1'b0;
      rc(ADDR_ERASE_HIGH, 8'h00);
      wr(ADDR_ERASE_HIGH, 8'h00);
      chk({31'h0, erasable}, 32'h0);
      flash_enable_i <= 1'b1;
      rc(ADDR_ERASE_HIGH, 8'h80);
      sw_standby_i <= 1'b1;
      tick(3);
      sw_standby_i <= 1'b0;
      rc(ADDR_ERASE_HIGH, 8'h00);
      wr(ADDR_PERMIT, 8'h01);
      wr(ADDR_ERASE_HIGH, 8'h02);
      wr(ADDR_UPPER_MODE, 8'h08);
      wr(ADDR_PERMIT, 8'h00);
      rc(ADDR_ERASE_HIGH, 8'h00);
      rc(ADDR_UPPER_MODE, 8'h00);
      wr(ADDR_PERMIT, 8'h01);
      // write without lane 0 must not touch the permit
      be <= 4'h0;
      wr(ADDR_PERMIT, 8'h00);
      be <= 4'h1;
      rc(ADDR_PERMIT, 8'h03);
      error_detect_i <= 1'b1;
      tick(1);
      error_detect_i <= 1'b0;
      rc(ADDR_UPPER_MODE, 8'h80);
      chk({31'h0, fault}, 32'h1);
      wr(ADDR_UPPER_MODE, 8'h20);
      tick(2);
      chk({31'h0, esu}, 32'h0);
      sw_standby_i <= 1'b1;
      tick(3);
      sw_standby_i <= 1'b0;
      rc(ADDR_UPPER_MODE, 8'h80);
      hw_standby_i <= 1'b1;
      tick(3);
      hw_standby_i <= 1'b0;
      rc(ADDR_UPPER_MODE, 8'h00);
      chk({31'h0, fault}, 32'h0);
      bus(1'b0, 4'h2, 8'h00);
      chk({30'h0, rsp}, 32'h2);
      tally_and_finish();
   end
   // hang guard: the whole sequence needs far fewer cycles
   initial
   begin
      tick(20000);
      n_mismatch++;
      tally_and_finish();
   end
endmodule
